// File: rtl/tsc_i2c_ctrl.sv
`timescale 1ns/1ns
`include "tsc_map.svh"
module tsc_i2c_ctrl #(
    parameter logic [4:0] DEV_ID = 5'h0b // Arbitrary value
) (
    // System clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Conversion clock domain
    input wire logic conversion_clock_i,
    input wire logic [11:0] adc_sample_i,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Address straps
    input wire logic [1:0] addr_select_pins_i,
    // Converter control
    output logic [3:0] function_select_o,
    output logic [1:0] power_down_select_o,
    output logic mode_8bit_o,
    output logic mux_connect_o,
    output logic x_drv_o,
    output logic y_drv_o,
    output logic conv_busy_o
);

    tsc_pkg::tsc_sys_s sys_reg, sys_next;
    tsc_pkg::tsc_cnv_s cnv_reg, cnv_next;

    // Total conversion clocks per processed result
    function automatic logic [7:0] conv_total(input logic m8);
        logic [7:0] per;
        per = m8 ? `TSC_CONV_CYC_8 : `TSC_CONV_CYC_12;
        conv_total = 8'(per * `TSC_CONV_COUNT + `TSC_FILTER_CYC - `TSC_OVERLAP_CYC);
    endfunction : conv_total

    // Driver enables for a function code
    function automatic logic [1:0] drv_of(input logic [3:0] f);
        logic [1:0] d;
        d = 2'h0;
        case (f)
            4'h8, 4'hc: d = 2'h2;
            4'h9, 4'hd: d = 2'h1;
            4'ha, 4'he, 4'hf: d = 2'h3;
            default: d = 2'h0;
        endcase
        drv_of = d;
    endfunction : drv_of

    logic scl_rise, scl_fall, start_c, stop_c, addr_match, done_edge;

    // Bus events from synchronised pins
    assign scl_rise = sys_reg.scl_b & ~sys_reg.scl_d;
    assign scl_fall = ~sys_reg.scl_b & sys_reg.scl_d;
    assign start_c = sys_reg.scl_b & sys_reg.scl_d & sys_reg.sda_d & ~sys_reg.sda_b;
    assign stop_c = sys_reg.scl_b & sys_reg.scl_d & ~sys_reg.sda_d & sys_reg.sda_b;
    assign addr_match = (sys_reg.sh[7:`TSC_ADDR_ID_LSB] == DEV_ID) &&
        (sys_reg.sh[`TSC_ADDR_ID_LSB-1:`TSC_ADDR_SEL_LSB] == sys_reg.sel_b);
    assign done_edge = sys_reg.done_b ^ sys_reg.done_d;

    // Bus protocol and acquisition control
    always_comb begin
        sys_next = sys_reg;
        sys_next.scl_a = scl_i;
        sys_next.scl_b = sys_reg.scl_a;
        sys_next.scl_d = sys_reg.scl_b;
        sys_next.sda_a = sda_i;
        sys_next.sda_b = sys_reg.sda_a;
        sys_next.sda_d = sys_reg.sda_b;
        sys_next.sel_a = addr_select_pins_i;
        sys_next.sel_b = sys_reg.sel_a;
        sys_next.done_a = cnv_reg.done_t;
        sys_next.done_b = sys_reg.done_a;
        sys_next.done_d = sys_reg.done_b;
        // Conversion finished: take result, drop drivers
        if (done_edge) begin
            sys_next.busy = 1'b0;
            sys_next.result = cnv_reg.res;
            sys_next.x_drv = 1'b0;
            sys_next.y_drv = 1'b0;
        end
        if (start_c || stop_c) begin
            sys_next.st = start_c ? tsc_pkg::ST_ADDR : tsc_pkg::ST_IDLE;
            sys_next.cnt = 4'h0;
            sys_next.oe = 1'b0;
            if (sys_reg.acq) begin
                sys_next.acq = 1'b0;
                sys_next.busy = 1'b1;
                sys_next.req_t = ~sys_reg.req_t;
            end
        end else begin
            case (sys_reg.st)
                tsc_pkg::ST_ADDR, tsc_pkg::ST_CMD, tsc_pkg::ST_EXTRA: begin
                    if (scl_rise) begin
                        sys_next.sh = {sys_reg.sh[6:0], sys_reg.sda_b};
                        sys_next.cnt = sys_reg.cnt + 4'h1;
                    end
                    if (scl_fall && sys_reg.st == tsc_pkg::ST_CMD &&
                        sys_reg.cnt == `TSC_FUNC_BITS) begin
                        sys_next.chan = sys_reg.sh[3:0];
                        sys_next.acq = 1'b1;
                        sys_next.busy = 1'b0;
                        {sys_next.x_drv, sys_next.y_drv} = drv_of(sys_reg.sh[3:0]);
                    end
                    if (scl_fall && sys_reg.cnt == `TSC_BITS_PER_BYTE) begin
                        sys_next.cnt = 4'h0;
                        if (sys_reg.st == tsc_pkg::ST_ADDR) begin
                            if (addr_match) begin
                                sys_next.oe = 1'b1;
                                sys_next.st = tsc_pkg::ST_ADDR_ACK;
                            end else begin
                                sys_next.st = tsc_pkg::ST_IDLE;
                            end
                        end else if (sys_reg.st == tsc_pkg::ST_CMD) begin
                            sys_next.oe = 1'b1;
                            sys_next.pd = sys_reg.sh[`TSC_CMD_PD_LSB+1:`TSC_CMD_PD_LSB];
                            sys_next.mode8 = sys_reg.sh[`TSC_CMD_MODE_BIT];
                            sys_next.st = tsc_pkg::ST_CMD_ACK;
                        end
                        // Extra bytes simply roll over unanswered
                    end
                end
                tsc_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (sys_reg.sh[`TSC_ADDR_RW_BIT]) begin
                            sys_next.sh = sys_reg.result[11:4];
                            sys_next.oe = ~sys_reg.result[11];
                            sys_next.second_sent = 1'b0;
                            sys_next.st = tsc_pkg::ST_TX;
                        end else begin
                            sys_next.oe = 1'b0;
                            sys_next.st = tsc_pkg::ST_CMD;
                        end
                    end
                end
                tsc_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        sys_next.oe = 1'b0;
                        sys_next.st = tsc_pkg::ST_EXTRA;
                    end
                end
                tsc_pkg::ST_TX: begin
                    if (scl_rise) begin
                        sys_next.cnt = sys_reg.cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (sys_reg.cnt == `TSC_BITS_PER_BYTE) begin
                            sys_next.oe = 1'b0;
                            sys_next.cnt = 4'h0;
                            sys_next.st = tsc_pkg::ST_TX_ACK;
                        end else begin
                            sys_next.sh = {sys_reg.sh[6:0], 1'b0};
                            sys_next.oe = ~sys_reg.sh[6];
                        end
                    end
                end
                tsc_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        sys_next.master_ack = ~sys_reg.sda_b;
                    end
                    if (scl_fall) begin
                        if (sys_reg.master_ack) begin
                            if (!sys_reg.second_sent && !sys_reg.mode8) begin
                                sys_next.sh = {sys_reg.result[3:0], 4'h0};
                            end else begin
                                sys_next.sh = `TSC_INVALID_BYTE;
                            end
                            sys_next.oe = ~sys_next.sh[7];
                            sys_next.second_sent = 1'b1;
                            sys_next.st = tsc_pkg::ST_TX;
                        end else begin
                            sys_next.st = tsc_pkg::ST_IDLE;
                        end
                    end
                end
                default: sys_next.st = tsc_pkg::ST_IDLE;
            endcase
        end
    end

    // System domain registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_reg <= '0;
            sys_reg.scl_a <= 1'b1;
            sys_reg.scl_b <= 1'b1;
            sys_reg.scl_d <= 1'b1;
            sys_reg.sda_a <= 1'b1;
            sys_reg.sda_b <= 1'b1;
            sys_reg.sda_d <= 1'b1;
            sys_reg.st <= tsc_pkg::ST_IDLE;
            sys_reg.result <= `TSC_RESULT_RST;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // Conversion timing in the conversion clock domain
    always_comb begin
        cnv_next = cnv_reg;
        cnv_next.req_a = sys_reg.req_t;
        cnv_next.req_b = cnv_reg.req_a;
        cnv_next.req_d = cnv_reg.req_b;
        if (cnv_reg.req_b ^ cnv_reg.req_d) begin
            // Mode is settled long before acquisition ends
            cnv_next.cnt = conv_total(sys_reg.mode8) - 8'h1;
            cnv_next.busy = 1'b1;
        end else if (cnv_reg.busy) begin
            if (cnv_reg.cnt == 8'h0) begin
                cnv_next.busy = 1'b0;
                cnv_next.res = adc_sample_i;
                cnv_next.done_t = ~cnv_reg.done_t;
            end else begin
                cnv_next.cnt = cnv_reg.cnt - 8'h1;
            end
        end
    end

    // Conversion domain registers
    always_ff @(posedge conversion_clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnv_reg <= '0;
            cnv_reg.res <= `TSC_RESULT_RST;
        end else begin
            cnv_reg <= cnv_next;
        end
    end

    // Outputs straight from flops, except sda_o which is tied low
    assign sda_o = 1'b0;
    assign sda_oe_o = sys_reg.oe;
    assign function_select_o = sys_reg.chan;
    assign power_down_select_o = sys_reg.pd;
    assign mode_8bit_o = sys_reg.mode8;
    assign mux_connect_o = sys_reg.acq;
    assign x_drv_o = sys_reg.x_drv;
    assign y_drv_o = sys_reg.y_drv;
    assign conv_busy_o = sys_reg.busy;

endmodule : tsc_i2c_ctrl

// File: rtl/tsc_map.svh
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Address byte layout
`define TSC_ADDR_RW_BIT 0
`define TSC_ADDR_SEL_LSB 1
`define TSC_ADDR_ID_LSB 3

// Command byte layout
`define TSC_CMD_FUNC_LSB 4
`define TSC_CMD_PD_LSB 2
`define TSC_CMD_MODE_BIT 1

// Bit counts on the bus
`define TSC_BITS_PER_BYTE 4'h8
`define TSC_FUNC_BITS 4'h4

// Conversion clock budget
`define TSC_CONV_CYC_12 8'h13
`define TSC_CONV_CYC_8 8'h10
`define TSC_CONV_COUNT 8'h07
`define TSC_FILTER_CYC 8'h13
`define TSC_OVERLAP_CYC 8'h04

// Result reset value and invalid read byte
`define TSC_RESULT_RST 12'h000
`define TSC_INVALID_BYTE 8'hff

`endif

// File: rtl/tsc_pkg.sv
package tsc_pkg;

    // Bus side states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_EXTRA,
        ST_TX,
        ST_TX_ACK
    } tsc_state_e;

    // System clock domain state
    typedef struct packed {
        logic scl_a;
        logic scl_b;
        logic scl_d;
        logic sda_a;
        logic sda_b;
        logic sda_d;
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        tsc_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic oe;
        logic master_ack;
        logic second_sent;
        logic [3:0] chan;
        logic [1:0] pd;
        logic mode8;
        logic acq;
        logic x_drv;
        logic y_drv;
        logic req_t;
        logic done_a;
        logic done_b;
        logic done_d;
        logic busy;
        logic [11:0] result;
    } tsc_sys_s;

    // Conversion clock domain state
    typedef struct packed {
        logic req_a;
        logic req_b;
        logic req_d;
        logic [7:0] cnt;
        logic busy;
        logic done_t;
        logic [11:0] res;
    } tsc_cnv_s;

endpackage : tsc_pkg

// File: verification/tsc_i2c_ctrl_monitor.sv
`timescale 1ns/1ns
module tsc_i2c_ctrl_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Watched pins
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic [3:0] function_select_o,
    input wire logic mode_8bit_o,
    input wire logic mux_connect_o,
    input wire logic x_drv_o,
    input wire logic y_drv_o,
    input wire logic conv_busy_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    logic [11:0] bcnt_reg;
    logic [11:0] bcnt_next;
    // Length of the busy span in system clocks
    always_comb bcnt_next = conv_busy_o ? bcnt_reg + 12'h001 : 12'h000;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) bcnt_reg <= 12'h000;
        else bcnt_reg <= bcnt_next;
    end
    property p_mux_off; conv_busy_o |-> !mux_connect_o; endproperty
    a_mux_off: assert property (p_mux_off) else $error("mux on in conversion");
    property p_conv_next; $fell(mux_connect_o) |-> ##[0:2] conv_busy_o; endproperty
    a_conv_next: assert property (p_conv_next) else $error("no conversion");
    property p_drv_hold; conv_busy_o && $past(conv_busy_o) |-> $stable({x_drv_o, y_drv_o}); endproperty
    a_drv_hold: assert property (p_drv_hold) else $error("drivers moved");
    property p_drv_acq; $rose(x_drv_o) || $rose(y_drv_o) |-> mux_connect_o; endproperty
    a_drv_acq: assert property (p_drv_acq) else $error("drivers outside acquisition");
    property p_drv_pos; x_drv_o || y_drv_o |-> function_select_o[3]; endproperty
    a_drv_pos: assert property (p_drv_pos) else $error("drivers for wrong code");
    property p_sda_low; $changed(sda_oe_o) |-> !scl_i; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda moved at scl high");
    property p_acq_low; $rose(mux_connect_o) |-> !scl_i; endproperty
    a_acq_low: assert property (p_acq_low) else $error("acquisition off scl fall");
    property p_conv_len; $fell(conv_busy_o) |-> (mode_8bit_o ? bcnt_reg inside {[12'h3f2:12'h44c]}
        : bcnt_reg inside {[12'h498:12'h4f6]}); endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length");
endmodule : tsc_i2c_ctrl_monitor
bind tsc_i2c_ctrl tsc_i2c_ctrl_monitor mon (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .function_select_o(function_select_o), .mode_8bit_o(mode_8bit_o),
    .mux_connect_o(mux_connect_o), .x_drv_o(x_drv_o), .y_drv_o(y_drv_o), .conv_busy_o(conv_busy_o));

// File: verification/tsc_i2c_master.sv
`timescale 1ns/1ns
module tsc_i2c_master (
    // Clock
    input wire logic mclk_i,
    // Bus lines, SDA pulled low while sda_pull_o is high
    input wire logic sda_i,
    output logic scl_o = 1'b1,
    output logic sda_pull_o = 1'b0,
    // Received bytes and acks
    output logic [7:0] rx_o = 8'h00,
    output logic rx_v_o = 1'b0
);
    // Set both lines after a third of a bit period
    task automatic lv(input logic c, input logic p);
        repeat (15) @(negedge mclk_i);
        scl_o = c;
        sda_pull_o = p;
    endtask : lv
    // START or repeated START, also ends a write cycle
    task automatic start();
        lv(scl_o, 1'b0);
        lv(1'b1, 1'b0);
        lv(1'b1, 1'b1);
        lv(1'b0, 1'b1);
    endtask : start
    // STOP
    task automatic stop();
        lv(1'b0, 1'b1);
        lv(1'b1, 1'b1);
        lv(1'b1, 1'b0);
    endtask : stop
    // One bit, line sampled at the end of SCL high
    task automatic bitx(input logic b, output logic r);
        lv(1'b0, ~b);
        lv(1'b1, ~b);
        repeat (15) @(negedge mclk_i);
        r = sda_i;
        scl_o = 1'b0;
    endtask : bitx
    // Hand a byte or ack to the bench
    task automatic note(input logic [7:0] v);
        rx_o = v;
        rx_v_o = 1'b1;
        @(negedge mclk_i);
        rx_v_o = 1'b0;
    endtask : note
    // Byte write with the slave's ack
    task automatic wbyte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        note({7'h00, r});
    endtask : wbyte
    // Byte read, then ack or not, line level in the ack slot noted
    task automatic rbyte(input logic ack);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        note(d);
        bitx(~ack, r);
        note({7'h00, r});
    endtask : rbyte
endmodule : tsc_i2c_master

// File: verification/touch_adc_i2c_cycle_control_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
$display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module touch_adc_i2c_cycle_control_bench;
    localparam logic [4:0] ID = 5'h0b; // Arbitrary value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic conversion_clock = 1'b0;
    logic [11:0] smp = 12'h000;
    logic [11:0] prev;
    logic [1:0] sel = 2'h0;
    logic [1:0] pd, pdv;
    logic [3:0] fs;
    logic [7:0] rx, ev;
    logic scl, pull, oe, sdo, rxv, m8, mux, xd, yd, busy, md, xe, ye;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    wire sda = ~(pull | oe);
    // Clocks: system 10 ns, conversion 80 ns
    always #5 mclk = ~mclk;
    always #40 conversion_clock = ~conversion_clock;
    tsc_i2c_ctrl #(.DEV_ID(ID)) uut (.mclk_i(mclk), .rst_i(rst), .conversion_clock_i(conversion_clock),
        .adc_sample_i(smp), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
        .addr_select_pins_i(sel), .function_select_o(fs), .power_down_select_o(pd),
        .mode_8bit_o(m8), .mux_connect_o(mux), .x_drv_o(xd), .y_drv_o(yd), .conv_busy_o(busy));
    tsc_i2c_master m (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull), .rx_o(rx),
        .rx_v_o(rxv));
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // Match each byte or ack from the bus with the oldest note
    always @(posedge mclk) begin
        if (rxv === 1'b1) begin
            ev = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(rx, ev)
        end
    end
    // Cycle ceiling
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            summarize();
        end
    end
    // Command write, ok selects a matching address
    task automatic wr(input logic [7:0] c, input logic ok);
        m.start();
        exp_q.push_back({7'h00, ~ok});
        m.wbyte({ID, sel ^ {1'b0, ~ok}, 1'b0});
        exp_q.push_back({7'h00, ~ok});
        m.wbyte(c);
    endtask : wr
    // Result read, ex acks the last valid byte and takes one more
    task automatic rd(input logic [11:0] v, input logic m8v, input logic ex, input logic st);
        if (st) m.start();
        exp_q.push_back(8'h00);
        m.wbyte({ID, sel, 1'b1});
        exp_q.push_back(v[11:4]);
        exp_q.push_back({7'h00, m8v & ~ex});
        m.rbyte(~m8v | ex);
        if (!m8v) begin
            exp_q.push_back({v[3:0], 4'h0});
            exp_q.push_back({7'h00, ~ex});
            m.rbyte(ex);
        end
        if (ex) begin
            exp_q.push_back(8'hff);
            exp_q.push_back(8'h01);
            m.rbyte(1'b0);
        end
    endtask : rd
    // Main sequence
    initial begin
        void'($urandom(83664));
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        prev = 12'h000;
        wr(8'hc0, 1'b0);
        m.stop();
        repeat (4) @(negedge mclk);
        `CHK({sdo, mux, busy}, 3'h0)
        for (int i = 0; i < 16; i++) begin
            smp = 12'($urandom);
            sel = 2'($urandom);
            {pdv, md} = 3'($urandom);
            xe = i inside {8, 10, 12, 14, 15};
            ye = i inside {9, 10, 13, 14, 15};
            wr({i[3:0], pdv, md, 1'b0}, 1'b1);
            if (i == 5) begin
                exp_q.push_back(8'h01);
                m.wbyte(8'h5a);
            end
            `CHK({mux, fs}, {1'b1, i[3:0]})
            `CHK({xd, yd, pd, m8}, {xe, ye, pdv, md})
            if (i[0]) m.start();
            else m.stop();
            repeat (4) @(negedge mclk);
            `CHK({mux, busy, xd, yd}, {2'b01, xe, ye})
            rd(prev, md, 1'b0, ~i[0]);
            m.stop();
            for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge mclk);
            `CHK({busy, xd, yd}, 3'h0)
            rd(smp, md, 1'b1, 1'b1);
            m.stop();
            prev = smp;
        end
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule : touch_adc_i2c_cycle_control_bench
